// file: hdl/fep_pcs.sv
// 100 Mbps framing, 4B/5B coding, scrambling, carrier, errors, link and speed
// Operation
// RULE1: Every MAC nibble passes the same coding chain, no field handling; the code sends the first two taken nibbles as J and K instead.
// RULE2: First preamble nibbles of a frame are sent as J then K.
// RULE3: Other nibbles map through 4B/5B; T then R follow the last.
// RULE4: Symbols are scrambled and sent serially, one bit per clock.
// RULE5: Receive order is line bit, descramble, 4B/5B decode, nibble out.
// RULE6: Descrambler locks its key register to the far end during idle.
// RULE7: Two non-adjacent zeros within ten received bits raise carrier at once.
// RULE8: Nibbles go to the MAC only after the full J K pair.
// RULE9: Missing J K after carrier drops carrier at once and flags error.
// RULE10: Link loss during a frame is a receive error.
// RULE11: A code outside the decode table is a receive error.
// RULE12: Idle inside a frame before T R is a receive error.
// RULE13: Receive error shows at once and lasts while the condition lasts.
// RULE14: Half duplex only: transmit and receive together report collision.
// RULE15: Link good follows a stable signal detect indication.
// RULE16: Four modes: 10 or 100 Mbps, half or full duplex.
// RULE17: Negotiation picks speed and duplex unless forced; forced setting is obeyed.
// RULE18: Speed may be automatic, forced to 10 or forced to 100.
// RULE19: Automatic speed with link pulses but no fast bursts falls to 10.
// RULE20: Speed change switches clocks within five milliseconds.
// RULE21: End pair codes 01101, 00111; idle 11111; unlisted codes invalid.
// RULE22: Key bit is sum modulo two of bits eleven and nine back.
// RULE23: Delimiter symbols are stripped; only data nibbles reach the MAC.
// RULE24: Carrier ends at T R, or after an error once idle returns; the code drops carrier as it enters the error state.
`timescale 1ns/10ps
`include "fep_params.svh"
module fep_pcs #(
    parameter int SW_CYC = `FEP_SW_MS * `FEP_CLK_KHZ // Speed switch delay in clocks
) (
    input logic clk, // 125 MHz core clock
    input logic nrst, // Async reset, active low
    input logic tx_en, // MAC transmit enable
    input logic [3:0] txd, // MAC transmit nibble
    output logic tx_take, // Nibble on txd taken this cycle
    output logic tx_bit, // Scrambled serial line bit
    input logic rx_lclk, // Recovered line clock pin
    input logic rx_bit, // Recovered line bit pin
    input logic sig_det, // Signal detect pin from medium
    input logic nlp_det, // Normal link pulses seen
    input logic flp_det, // Fast link pulse bursts seen
    input logic an_done, // Negotiation result valid
    input logic an_100, // Negotiated 100 Mbps
    input logic an_full, // Negotiated full duplex
    input logic [1:0] frc_spd, // Speed: auto, forced 10, forced 100
    input logic frc_dup, // Force duplex
    input logic frc_full, // Forced duplex value
    output logic [3:0] rxd, // Received nibble
    output logic rx_vld, // Received nibble strobe
    output logic rx_dv, // Frame data phase
    output logic crs, // Carrier sense
    output logic rx_er, // Receive error
    output logic col, // Collision
    output logic link_good, // Link integrity
    output logic clk_sel100, // Transmit and receive clocks at 100 rate
    output fep_pkg::fep_mode_t mode // Operating mode
);
    import fep_pkg::*;

    fep_st_t s;
    fep_st_t n;
    logic lclk2;
    logic rbit2;
    logic sd2;
    logic nlp2;
    logic flp2;
    logic tx_key;
    logic rx_key;
    logic tx_adv;
    logic rx_adv;
    logic rx_ld;
    logic e100;
    logic tbnd;
    logic dbit;
    logic bnd;
    logic want100;
    logic [9:0] w_n;
    logic [4:0] sym;
    logic [4:0] dv;

    function automatic logic [4:0] fep_enc(input logic [3:0] nib);
        logic [4:0] c;
        case (nib)
            4'h0: c = 5'h1e;
            4'h1: c = 5'h09;
            4'h2: c = 5'h14;
            4'h3: c = 5'h15;
            4'h4: c = 5'h0a;
            4'h5: c = 5'h0b;
            4'h6: c = 5'h0e;
            4'h7: c = 5'h0f;
            4'h8: c = 5'h12;
            4'h9: c = 5'h13;
            4'ha: c = 5'h16;
            4'hb: c = 5'h17;
            4'hc: c = 5'h1a;
            4'hd: c = 5'h1b;
            4'he: c = 5'h1c;
            default: c = 5'h1d;
        endcase
        return c;
    endfunction : fep_enc

    // Valid flag on top, nibble below; unlisted codes come back invalid
    function automatic logic [4:0] fep_dec(input logic [4:0] code);
        logic [4:0] r;
        r = '0;
        for (int k = 0; k < 16; k++) begin
            if (fep_enc(4'(k)) == code) begin
                r = {1'b1, 4'(k)};
            end
        end
        return r;
    endfunction : fep_dec

    function automatic logic fep_two_zeros(input logic [9:0] w);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < $bits(w); i++) begin
            for (int j = i + 2; j < $bits(w); j++) begin
                if (!w[i] && !w[j]) begin
                    hit = 1'b1;
                end
            end
        end
        return hit;
    endfunction : fep_two_zeros

    assign {lclk2, rbit2, sd2, nlp2, flp2} = s.s2;

    fep_lfsr u_tx_scr (
        .clk(clk),
        .nrst(nrst),
        .adv(tx_adv),
        .ld(1'b0),
        .ld_bit(1'b0),
        .key(tx_key)
    );

    fep_lfsr u_rx_scr (
        .clk(clk),
        .nrst(nrst),
        .adv(rx_adv),
        .ld(rx_ld),
        .ld_bit(~rbit2),
        .key(rx_key)
    );

    always_comb begin
        n = s;
        n.s1 = {rx_lclk, rx_bit, sig_det, nlp_det, flp_det};
        n.s2 = s.s1;
        n.lclk_p = lclk2;
        n.rx_vld = 1'b0;
        tx_take = 1'b0;
        tx_adv = 1'b0;
        // Speed and duplex choice
        case (frc_spd) // RULE18
            `FEP_SPD_10: want100 = 1'b0;
            `FEP_SPD_100: want100 = 1'b1;
            default: want100 = (nlp2 && !flp2) ? 1'b0 : (an_done ? an_100 : s.spd100); // RULE19 RULE17
        endcase
        if (frc_dup) begin
            n.full = frc_full; // RULE17
        end else if (frc_spd != `FEP_SPD_100 && frc_spd != `FEP_SPD_10 && nlp2 && !flp2) begin
            n.full = 1'b0;
        end else if (an_done) begin
            n.full = an_full;
        end
        if (want100 != s.spd100) begin
            if (s.sw_cnt == 20'(SW_CYC - 1)) begin
                n.spd100 = want100; // RULE20
                n.sw_cnt = '0;
            end else begin
                n.sw_cnt = s.sw_cnt + 20'd1;
            end
        end else begin
            n.sw_cnt = '0;
        end
        // Link integrity from filtered signal detect
        if (!sd2) begin
            n.sd_cnt = '0;
            n.link_ok = 1'b0;
        end else if (s.sd_cnt == `FEP_SD_STABLE) begin
            n.link_ok = 1'b1; // RULE15
        end else begin
            n.sd_cnt = s.sd_cnt + 8'd1;
        end
        // Transmit symbol engine
        tbnd = s.tbit == `FEP_SYM_LAST;
        if (s.spd100) begin
            tx_adv = 1'b1;
            n.tbit = tbnd ? '0 : s.tbit + 3'd1;
            n.tsh = {s.tsh[3:0], 1'b1};
            n.tx_bit = s.tsh[4] ^ tx_key; // RULE4
            if (tbnd) begin
                case (s.tst)
                    TX_IDLE: begin
                        if (tx_en) begin
                            n.tsh = `FEP_SYM_J; // RULE2
                            n.tst = TX_K;
                            tx_take = 1'b1;
                        end else begin
                            n.tsh = `FEP_SYM_I;
                        end
                    end
                    TX_K: begin
                        n.tsh = `FEP_SYM_K; // RULE2
                        n.tst = TX_DATA;
                        tx_take = 1'b1;
                    end
                    TX_DATA: begin
                        if (tx_en) begin
                            n.tsh = fep_enc(txd); // RULE1 RULE3
                            tx_take = 1'b1;
                        end else begin
                            n.tsh = `FEP_SYM_T; // RULE3 RULE21
                            n.tst = TX_R;
                        end
                    end
                    default: begin
                        n.tsh = `FEP_SYM_R; // RULE3 RULE21
                        n.tst = TX_IDLE;
                    end
                endcase
            end
        end else begin
            n.tst = TX_IDLE;
            n.tx_bit = 1'b0;
        end
        n.tx_act = n.tst != TX_IDLE;
        n.col = s.crs && s.tx_act && !s.full; // RULE14
        // Receive chain, one step per line clock rise
        e100 = lclk2 && !s.lclk_p && s.spd100;
        rx_adv = e100;
        rx_ld = !s.locked;
        dbit = rbit2 ^ rx_key; // RULE5
        w_n = {s.win[8:0], dbit};
        sym = w_n[4:0];
        dv = fep_dec(sym);
        bnd = s.rcnt == `FEP_SYM_LAST;
        if (e100) begin
            if (!s.locked) begin
                n.lock_cnt = dbit ? s.lock_cnt + 7'd1 : '0; // RULE6
                if (s.lock_cnt == `FEP_LOCK_BITS) begin
                    n.locked = 1'b1;
                end
            end else begin
                n.win = w_n;
                n.rcnt = bnd ? '0 : s.rcnt + 3'd1;
                case (s.rst)
                    RX_IDLE: begin
                        if (fep_two_zeros(w_n)) begin
                            n.crs = 1'b1; // RULE7
                            n.rst = RX_SSD;
                            n.rcnt = '0;
                        end
                    end
                    RX_SSD: begin
                        if (bnd && w_n == `FEP_JK_PAIR) begin
                            n.rst = RX_DATA; // RULE8 RULE23
                        end else if (bnd) begin
                            n.rst = RX_BAD; // RULE9
                            n.crs = 1'b0;
                        end
                    end
                    RX_DATA: begin
                        if (bnd) begin
                            n.serr = 1'b0;
                            if (sym == `FEP_SYM_T) begin
                                n.rst = RX_T; // RULE23
                            end else if (sym == `FEP_SYM_I) begin
                                n.rst = RX_BAD; // RULE12
                                n.crs = 1'b0;
                            end else if (dv[4]) begin
                                n.rxd = dv[3:0]; // RULE5
                                n.rx_vld = 1'b1;
                            end else begin
                                n.serr = 1'b1; // RULE11 RULE21
                            end
                        end
                    end
                    RX_T: begin
                        if (bnd) begin
                            n.rst = (sym == `FEP_SYM_R) ? RX_IDLE : RX_BAD; // RULE24 RULE21
                            n.crs = 1'b0;
                            // Forget the end pair so its zeros cannot raise a false carrier
                            n.win = `FEP_IDLE_WIN;
                        end
                    end
                    default: ;
                endcase
            end
        end
        if (s.rst == RX_BAD) begin
            n.serr = 1'b0;
            if (s.link_ok && s.win == `FEP_IDLE_WIN) begin
                n.rst = RX_IDLE; // RULE24
            end
        end
        if (!s.link_ok || !s.spd100) begin
            n.locked = 1'b0;
            n.lock_cnt = '0;
            // Window starts as idle so the first locked bit cannot raise carrier
            n.win = `FEP_IDLE_WIN;
            if (s.rst != RX_IDLE) begin
                n.rst = RX_BAD; // RULE10
                n.crs = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s <= '0;
            s.tsh <= `FEP_SYM_I;
            s.spd100 <= 1'b1;
        end else begin
            s <= n;
        end
    end

    assign tx_bit = s.tx_bit;
    assign rxd = s.rxd;
    assign rx_vld = s.rx_vld;
    assign rx_dv = s.rst == RX_DATA;
    assign crs = s.crs;
    assign rx_er = s.rst == RX_BAD || s.serr; // RULE13
    assign col = s.col;
    assign link_good = s.link_ok;
    assign clk_sel100 = s.spd100;
    assign mode = fep_mode_t'({s.spd100, s.full}); // RULE16

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    jk_start_a: assert property ((s.tst == TX_IDLE && tbnd && tx_en && s.spd100) |=> // RULE2
        s.tst == TX_K && s.tsh == `FEP_SYM_J)
        else $error("frame did not open with J");

    tr_end_a: assert property ((s.tst == TX_DATA && tbnd && !tx_en && s.spd100) |=> // RULE3
        s.tsh == `FEP_SYM_T ##5 (s.tst == TX_IDLE && s.tsh == `FEP_SYM_R))
        else $error("end pair not sent");

    crs_fast_a: assert property ((e100 && s.locked && s.link_ok && s.rst == RX_IDLE // RULE7
        && fep_two_zeros(w_n)) |=> s.crs && s.rst == RX_SSD)
        else $error("carrier not raised");

    false_crs_a: assert property ((e100 && s.locked && s.rst == RX_SSD && bnd // RULE9
        && w_n != `FEP_JK_PAIR) |=> !s.crs && rx_er)
        else $error("false carrier not flagged");

    nib_in_frame_a: assert property (s.rx_vld |-> $past(s.rst) == RX_DATA && s.crs) // RULE8
        else $error("nibble outside frame");

    link_err_a: assert property ((!s.link_ok && s.rst inside {RX_SSD, RX_DATA, RX_T}) // RULE10
        |=> s.rst == RX_BAD && rx_er)
        else $error("link loss not flagged");

    bad_sym_a: assert property ((e100 && s.locked && s.link_ok && s.rst == RX_DATA && bnd // RULE11
        && !dv[4] && sym != `FEP_SYM_T && sym != `FEP_SYM_I) |=> rx_er [*1] ##0 !s.rx_vld)
        else $error("invalid code not flagged");

    col_half_a: assert property (s.full |=> !s.col) // RULE14
        else $error("collision in full duplex");

    col_set_a: assert property ((s.crs && s.tx_act && !s.full) |=> s.col) // RULE14
        else $error("collision missed");

    spd_hold_a: assert property ((want100 == s.spd100) |=> $stable(s.spd100)) // RULE20
        else $error("speed changed without cause");
endmodule : fep_pcs

// file: hdl/fep_params.svh
// Constants of the 100 Mbps coding layer
`ifndef FEP_PARAMS_SVH
`define FEP_PARAMS_SVH
`define FEP_SYM_J 5'h18
`define FEP_SYM_K 5'h11
`define FEP_SYM_T 5'h0d
`define FEP_SYM_R 5'h07
`define FEP_SYM_I 5'h1f
`define FEP_JK_PAIR 10'h311
`define FEP_IDLE_WIN 10'h3ff
`define FEP_SYM_LAST 3'h4
`define FEP_LFSR_SEED 11'h7ff
`define FEP_TAP_N11 10
`define FEP_TAP_N9 8
`define FEP_LOCK_BITS 7'h3c
`define FEP_SD_STABLE 8'h10
`define FEP_CLK_KHZ 125000
`define FEP_SW_MS 5
`define FEP_SPD_10 2'h1
`define FEP_SPD_100 2'h2
`endif

// file: hdl/fep_pkg.sv
// Types of the 100 Mbps coding layer
package fep_pkg;
    typedef enum logic [1:0] {FEP_M10H, FEP_M10F, FEP_M100H, FEP_M100F} fep_mode_t;
    typedef enum logic [1:0] {TX_IDLE, TX_K, TX_DATA, TX_R} fep_tx_t;
    typedef enum logic [2:0] {RX_IDLE, RX_SSD, RX_DATA, RX_T, RX_BAD} fep_rx_t;
    typedef struct packed {
        logic [10:0] st;
    } fep_lfsr_t;
    typedef struct packed {
        logic [4:0] s1;
        logic [4:0] s2;
        logic lclk_p;
        fep_tx_t tst;
        logic [2:0] tbit;
        logic [4:0] tsh;
        logic tx_bit;
        logic tx_act;
        logic locked;
        logic [6:0] lock_cnt;
        logic [9:0] win;
        fep_rx_t rst;
        logic [2:0] rcnt;
        logic [3:0] rxd;
        logic rx_vld;
        logic serr;
        logic crs;
        logic col;
        logic [7:0] sd_cnt;
        logic link_ok;
        logic spd100;
        logic full;
        logic [19:0] sw_cnt;
    } fep_st_t;
endpackage : fep_pkg

// file: hdl/fep_lfsr.sv
// Eleven-stage scrambler key generator with load path for lock
`timescale 1ns/10ps
`include "fep_params.svh"
module fep_lfsr (
    input logic clk, // Core clock
    input logic nrst, // Async reset, active low
    input logic adv, // Step one bit
    input logic ld, // Shift in ld_bit instead of key
    input logic ld_bit, // Recovered key bit
    output logic key // Key bit for current step
);
    import fep_pkg::*;
    fep_lfsr_t s_q;
    fep_lfsr_t s_d;

    assign key = s_q.st[`FEP_TAP_N11] ^ s_q.st[`FEP_TAP_N9]; // RULE22

    always_comb begin
        s_d = s_q;
        if (adv) begin
            s_d.st = {s_q.st[9:0], ld ? ld_bit : key}; // RULE22
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_q.st <= `FEP_LFSR_SEED;
        end else begin
            s_q <= s_d;
        end
    end

    key_recur_a: assert property (@(posedge clk) disable iff (!nrst) // RULE22
        (adv && !ld) ##1 (adv && !ld) |=> s_q.st[1] == $past(s_q.st[10] ^ s_q.st[8], 2))
        else $error("scrambler recurrence broken");
endmodule : fep_lfsr

// file: bench/fep_partner.sv
// Far-end link partner: scrambled symbol source and transmit monitor
`timescale 1ns/10ps
module fep_partner (
    input wire logic clk, // Core clock
    input wire logic nrst, // Reset, active low
    input wire logic tx_bit, // Device line bit
    output logic rx_lclk, // Line clock to device
    output logic rx_bit // Line bit to device
);
    logic [10:0] key_q = 11'h2a5;
    logic [10:0] hk = '0;
    logic [9:0] sh = '0;
    logic [2:0] cnt = '0;
    int nlk = 0;
    logic inf = 0;
    logic [4:0] got[$];
    initial begin
        rx_lclk = 0;
        rx_bit = 1;
    end
    // Clock only moves while a symbol is on the line
    task automatic send(input logic [4:0] s);
        for (int i = 4; i >= 0; i--) begin
            rx_bit = s[i] ^ key_q[10] ^ key_q[8];
            key_q = {key_q[9:0], key_q[10] ^ key_q[8]};
            #32 rx_lclk = 1;
            #32 rx_lclk = 0;
        end
    endtask : send
    // Locks on idle, then collects symbols from J K up to R
    always @(posedge clk) begin
        logic k;
        k = hk[10] ^ hk[8];
        if (!nrst) begin
            nlk = 0;
        end else if (nlk < 40) begin
            k = ~tx_bit;
            nlk++;
        end
        hk = {hk[9:0], k};
        if (nlk >= 40) begin
            sh = {sh[8:0], tx_bit ^ k};
            if (!inf && sh == 10'h311) begin
                inf = 1;
                cnt = 0;
            end else if (inf && ++cnt == 5) begin
                got.push_back(sh[4:0]);
                cnt = 0;
                inf = (sh[4:0] != 5'h07);
            end
        end
    end
endmodule : fep_partner

// file: bench/testbench.sv
// Self-checking bench for the 100 Mbps coding layer
`timescale 1ns/10ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin error_cnt++; \
    $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module testbench;
    import fep_pkg::*;
    localparam int SW = 20;
    logic clk = 0;
    logic nrst = 0;
    logic tx_en = 0;
    logic [3:0] txd = 4'h0;
    logic sig_det = 0;
    logic nlp_det = 0;
    logic flp_det = 0;
    logic an_done = 0;
    logic an_100 = 0;
    logic an_full = 0;
    logic [1:0] frc_spd = 2'h0;
    logic frc_dup = 0;
    logic frc_full = 0;
    logic tx_take, tx_bit, rx_lclk, rx_bit, rx_vld, rx_dv, crs, rx_er, col, link_good, clk_sel100;
    logic [3:0] rxd;
    fep_mode_t mode;
    int error_cnt = 0;
    int n_compared = 0;
    int cyc = 0;
    logic er_seen = 0;
    logic col_seen = 0;
    logic [3:0] rq[$];
    logic [4:0] enc[16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
        5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
    fep_pcs #(.SW_CYC(SW)) u_fep_pcs (.clk, .nrst, .tx_en, .txd, .tx_take, .tx_bit, .rx_lclk, .rx_bit,
        .sig_det, .nlp_det, .flp_det, .an_done, .an_100, .an_full, .frc_spd, .frc_dup, .frc_full,
        .rxd, .rx_vld, .rx_dv, .crs, .rx_er, .col, .link_good, .clk_sel100, .mode);
    fep_partner u_fep_partner (.clk, .nrst, .tx_bit, .rx_lclk, .rx_bit);
    always #4 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (rx_vld === 1'b1) rq.push_back(rxd);
        if (rx_er === 1'b1) er_seen = 1;
        if (col === 1'b1) col_seen = 1;
        if (cyc == 30000) begin
            error_cnt++;
            complete_run();
        end
    end
    task automatic complete_run;
        $display("Compared %0d, errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : complete_run
    task automatic clks(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : clks
    task automatic sym(input logic [4:0] s);
        u_fep_partner.send(s);
    endtask : sym
    task automatic idle(input int n);
        repeat (n) sym(5'h1f);
    endtask : idle
    task automatic jk;
        sym(5'h18);
        sym(5'h11);
        clks(2);
    endtask : jk
    task automatic relink;
        clks(1);
        sig_det = 1;
        clks(30);
        `CHK(link_good, 1'b1)
        idle(16);
    endtask : relink
    task automatic put(input logic [3:0] n);
        int w = 0;
        txd = n;
        do begin
            @(posedge clk);
            w++;
        end while (tx_take !== 1'b1 && w < 20);
        `CHK(tx_take, 1'b1)
        #1;
    endtask : put
    task automatic t_tx;
        logic [3:0] d[6] = '{4'h5, 4'h5, 4'h5, 4'hd, 4'h0, 4'hf};
        logic [4:0] x[$];
        clks(1);
        u_fep_partner.got.delete();
        tx_en = 1;
        foreach (d[i]) put(d[i]);
        tx_en = 0;
        clks(40);
        for (int i = 2; i < 6; i++) x.push_back(enc[d[i]]);
        x.push_back(5'h0d);
        x.push_back(5'h07);
        `CHK(u_fep_partner.got.size(), 6)
        foreach (x[i]) `CHK(u_fep_partner.got[i], x[i])
    endtask : t_tx
    task automatic t_rx;
        logic [3:0] d[4] = '{4'h5, 4'hd, 4'h0, 4'ha};
        rq.delete();
        er_seen = 0;
        jk();
        `CHK(crs, 1'b1)
        `CHK(rx_dv, 1'b1)
        foreach (d[i]) sym(enc[d[i]]);
        sym(5'h0d);
        sym(5'h07);
        idle(2);
        `CHK(crs, 1'b0)
        `CHK(rq.size(), 4)
        foreach (d[i]) `CHK(rq[i], d[i])
        `CHK(er_seen, 1'b0)
    endtask : t_rx
    // Broken frame, then idle: error seen, then carrier and error gone
    task automatic bad_frame(input logic [4:0] s[$]);
        er_seen = 0;
        foreach (s[i]) sym(s[i]);
        `CHK(er_seen, 1'b1)
        idle(4);
        `CHK(crs, 1'b0)
        `CHK(rx_er, 1'b0)
    endtask : bad_frame
    task automatic t_link_loss;
        er_seen = 0;
        jk();
        sym(enc[4]);
        sig_det = 0;
        sym(enc[5]);
        sym(enc[6]);
        `CHK(er_seen, 1'b1)
        `CHK(link_good, 1'b0)
        relink();
    endtask : t_link_loss
    task automatic t_col;
        clks(1);
        tx_en = 1;
        txd = 4'h5;
        col_seen = 0;
        jk();
        sym(enc[1]);
        `CHK(col_seen, 1'b1)
        frc_dup = 1;
        frc_full = 1;
        clks(3);
        col_seen = 0;
        sym(enc[2]);
        sym(5'h0d);
        sym(5'h07);
        `CHK(col_seen, 1'b0)
        `CHK(mode, FEP_M100F)
        clks(1);
        tx_en = 0;
        idle(2);
    endtask : t_col
    task automatic spd(input logic [1:0] f, input logic n, input logic a, input fep_mode_t m);
        frc_spd = f;
        nlp_det = n;
        an_100 = a;
        clks(SW + 5);
        `CHK(mode, m)
        `CHK(clk_sel100, m[1])
    endtask : spd
    task automatic t_speed;
        frc_full = 0;
        frc_spd = 2'h1;
        clks(SW / 2);
        `CHK(clk_sel100, 1'b1)
        spd(2'h1, 0, 0, FEP_M10H);
        an_done = 1;
        an_full = 1;
        frc_dup = 0;
        spd(2'h0, 0, 1, FEP_M100F);
        spd(2'h0, 1, 1, FEP_M10H);
        flp_det = 1;
        spd(2'h0, 1, 0, FEP_M10F);
        spd(2'h2, 1, 0, FEP_M100F);
    endtask : t_speed
    initial begin
        clks(4);
        nrst = 1;
        `CHK(crs, 1'b0)
        `CHK(mode, FEP_M100H)
        `CHK(clk_sel100, 1'b1)
        relink();
        t_tx();
        t_rx();
        bad_frame('{5'h18, 5'h11, 5'h09, 5'h00, 5'h14, 5'h0d, 5'h07});
        bad_frame('{5'h18, 5'h11, 5'h15, 5'h1f, 5'h1f});
        bad_frame('{5'h18, 5'h0f, 5'h1f});
        t_link_loss();
        t_col();
        t_speed();
        complete_run();
    end
endmodule : testbench
